/* File: inc/epcrp_cfg.svh */
// Purpose: constants for the emulator probe, clock and reset port
// Assumes: core clock of 125 MHz
// Notes:   the offsets, bit positions, widths and the option and sync reset values sit here
`ifndef EPCRP_CFG_SVH
`define EPCRP_CFG_SVH

`define EPCRP_ADDR_W          13
`define EPCRP_MEM_DEPTH       8192
`define EPCRP_PROBE_W         4
`define EPCRP_OPT_ADDR_SMALL  13'h0fe2
`define EPCRP_OPT_ADDR_LARGE  13'h1fe2
`define EPCRP_OPT_W           4
`define EPCRP_OPT_RESET       4'h0
`define EPCRP_OPT_PULLUP_BIT  0
`define EPCRP_SYNC_RESET      1'b1
`define EPCRP_LOW_DIV         2

`endif

/* File: inc/epcrp_pkg.sv */
// Purpose: types for the emulator probe, clock and reset port
// Assumes: nothing beyond the constants header
// Notes:   emulation modes and instruction phase states
package epcrp_pkg;

  typedef enum logic [1:0] {
    EPCRP_MODE_EVAL   = 2'b00,
    EPCRP_MODE_REALTM = 2'b01,
    EPCRP_MODE_STEP   = 2'b10,
    EPCRP_MODE_INIT   = 2'b11
  } epcrp_mode_t;

  typedef enum logic [1:0] {
    EPCRP_PH_IDLE = 2'b00,
    EPCRP_PH_S1A  = 2'b01,
    EPCRP_PH_S1B  = 2'b10,
    EPCRP_PH_S2   = 2'b11
  } epcrp_phase_t;

endpackage : epcrp_pkg

/* File: rtl/epcrp_sync.sv */
// Purpose: two-stage synchroniser for a bus of asynchronous inputs
// Assumes: one clock, synchronous reset
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module epcrp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import epcrp_pkg::*;

  logic [WIDTH-1:0] stage1_q;

  // both stages clear together; per-bit stages come from a generate loop
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (srst) begin
          stage1_q[gi] <= 1'b0;
          syncOut[gi]  <= 1'b0;
        end else begin
          stage1_q[gi] <= asyncIn[gi];
          syncOut[gi]  <= stage1_q[gi];
        end
      end
    end
  endgenerate

endmodule : epcrp_sync

/* File: rtl/epcrp_clkdiv.sv */
// Purpose: low-speed clock source select and divide-by-two
// Assumes: clock sources arrive as levels sampled on core_clk
// Notes:   output is an enable-style level, not a real clock net
`timescale 1ns/1ps
module epcrp_clkdiv (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic selExt,
  input  wire logic internalSrc,
  input  wire logic userSrc,
  output logic      divOut,
  output logic      divTick
);
  import epcrp_pkg::*;

  logic srcSel;
  logic srcPrev_q;
  logic rise;

  // pick the source, then toggle on each rising edge: divide by two
  assign srcSel = selExt ? userSrc : internalSrc;
  assign rise   = srcSel & ~srcPrev_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      srcPrev_q <= 1'b0;
      divOut    <= 1'b0;
      divTick   <= 1'b0;
    end else begin
      srcPrev_q <= srcSel;
      divTick   <= rise & divOut; // one pulse per divided period
      if (rise)
        divOut <= ~divOut;
    end
  end

endmodule : epcrp_clkdiv

/* File: rtl/epcrp_port.sv */
// Purpose: target-side probe, clock select and reset gating of the emulator
// Assumes: all pins synchronous to core_clk after the synchronisers
// Notes:   instruction phases are flagged by the core as pulses
//
// Summary of operation
// - rising external break edge raises break when enabled
// - break request aligned to start of S2
// - one sync-pulse bit per code address
// - sync output low in first S1 half
// - only first-word sync bits take effect
// - four probe inputs latched at S1 start
// - probe values recorded with trace entries
// - separate source selectors for both clocks
// - time-base always runs from low-speed clock
// - core runs from low or high clock
// - low-speed clock is selected input halved
// - high clock delivered at once when started
// - reset from controller, optionally user input
// - user reset never honoured in single step
// - user reset accepted only while run lit
// - pull-up option word at one of two code addresses
// - comparator mode disconnects shared input port
// - trace entries recorded only in real time
`timescale 1ns/1ps
`include "epcrp_cfg.svh"
module epcrp_port (
  input  wire logic                         core_clk,
  input  wire logic                         srst,
  // probe cable
  input  wire logic                         externalBreakInput,
  input  wire logic [`EPCRP_PROBE_W-1:0]    probeTraceInputs,
  output logic                              syncPulseOut,
  input  wire logic                         extBreakEnable,
  output logic                              breakRequest,
  // instruction sequencing from the evaluation core
  input  wire logic                         instrS1Start,
  input  wire logic                         instrS1Half,
  input  wire logic                         instrS2Start,
  input  wire logic                         instrFirstWord,
  input  wire logic [`EPCRP_ADDR_W-1:0]     instrAddr,
  input  wire epcrp_pkg::epcrp_mode_t       emuMode,
  input  wire logic                         runIndicator,
  output logic                              traceRecord,
  output logic [`EPCRP_PROBE_W-1:0]         traceProbeData,
  // host access to the per-address bits and option word
  input  wire logic                         hostSyncWrite,
  input  wire logic [`EPCRP_ADDR_W-1:0]     hostSyncAddr,
  input  wire logic                         hostSyncData,
  input  wire logic                         hostOptWrite,
  input  wire logic [`EPCRP_OPT_W-1:0]      hostOptData,
  output logic [`EPCRP_OPT_W-1:0]           hostOptRead,
  input  wire logic                         largeMap,
  output logic                              resetPullupSelect,
  // clocks
  input  wire logic                         lowClockSourceSwitch,
  input  wire logic                         highClockSourceSwitch,
  input  wire logic                         internalLowSrc,
  input  wire logic                         internalHighSrc,
  input  wire logic                         userLowClockInput,
  input  wire logic                         userHighClockInput,
  input  wire logic                         oscillatorStartBit,
  input  wire logic                         coreClockSelHigh,
  output logic                              lowSpeedClock,
  output logic                              highSpeedClock,
  output logic                              coreClockOut,
  output logic                              timeBaseTick,
  // reset
  input  wire logic                         ctrlReset,
  input  wire logic                         userResetEnable,
  input  wire logic                         userResetInput_n,
  output logic                              evalReset,
  // comparator select and shared port pins
  input  wire logic                         comparatorSelectSwitch,
  input  wire logic [1:0]                   sharedPortPins,
  output logic [1:0]                        sharedPortIn
);
  import epcrp_pkg::*;

  logic                      brkSync;
  logic [`EPCRP_PROBE_W-1:0] probeSync;
  logic                      brkPrev_q;
  logic                      brkPend_q;
  logic                      syncMem [0:`EPCRP_MEM_DEPTH-1];
  logic                      syncBit_q;
  logic [`EPCRP_OPT_W-1:0]   optWord_q;
  epcrp_phase_t              phase_q;
  logic                      highSel;
  logic                      lowDiv;
  logic                      lowTick;
  logic                      userRstOk;
  logic [`EPCRP_ADDR_W-1:0]  optAddr;

  // break and probe pins are synchronised before edge detection or sampling
  epcrp_sync #(.WIDTH(1)) u_brkSync (
    .core_clk (core_clk),
    .srst     (srst),
    .asyncIn  (externalBreakInput),
    .syncOut  (brkSync)
  );

  epcrp_sync #(.WIDTH(`EPCRP_PROBE_W)) u_probeSync (
    .core_clk (core_clk),
    .srst     (srst),
    .asyncIn  (probeTraceInputs),
    .syncOut  (probeSync)
  );

  // break edge held pending until the next S2 start, then pulsed out
  always_ff @(posedge core_clk) begin
    if (srst) begin
      brkPrev_q    <= 1'b0;
      brkPend_q    <= 1'b0;
      breakRequest <= 1'b0;
    end else begin
      brkPrev_q    <= brkSync;
      breakRequest <= instrS2Start & brkPend_q;
      // a new edge in the S2 cycle wins over the clear
      if (extBreakEnable & brkSync & ~brkPrev_q)
        brkPend_q <= 1'b1;
      else if (instrS2Start | ~extBreakEnable)
        brkPend_q <= 1'b0;
    end
  end

  // per-address sync bits, written by the host; no reset on the array
  always_ff @(posedge core_clk) begin
    if (hostSyncWrite)
      syncMem[hostSyncAddr] <= hostSyncData;
  end

  // latch the bit at S1 start, first instruction words only
  always_ff @(posedge core_clk) begin
    if (srst)
      syncBit_q <= 1'b0;
    else if (instrS1Start)
      syncBit_q <= instrFirstWord & syncMem[instrAddr];
  end

  // phase tracker: S1 first half runs from S1 start to the half mark
  always_ff @(posedge core_clk) begin
    if (srst)
      phase_q <= EPCRP_PH_IDLE;
    else begin
      case (phase_q)
        EPCRP_PH_IDLE: if (instrS1Start) phase_q <= EPCRP_PH_S1A;
        EPCRP_PH_S1A:  if (instrS1Half)  phase_q <= EPCRP_PH_S1B;
        EPCRP_PH_S1B:  if (instrS2Start) phase_q <= EPCRP_PH_S2;
        EPCRP_PH_S2:   if (instrS1Start) phase_q <= EPCRP_PH_S1A;
        default:                         phase_q <= EPCRP_PH_IDLE;
      endcase
    end
  end

  // registered output; lags the phase by one cycle
  always_ff @(posedge core_clk) begin
    if (srst)
      syncPulseOut <= `EPCRP_SYNC_RESET;
    else
      syncPulseOut <= ~((phase_q == EPCRP_PH_S1A) & syncBit_q & ~instrS1Half);
  end

  // probe sample at S1 start, marked as recordable only in real time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      traceProbeData <= '0;
      traceRecord    <= 1'b0;
    end else begin
      traceRecord <= instrS1Start & (emuMode == EPCRP_MODE_REALTM);
      if (instrS1Start)
        traceProbeData <= probeSync;
    end
  end

  // option word lives at one of two code addresses by map size
  assign optAddr = largeMap ? `EPCRP_OPT_ADDR_LARGE : `EPCRP_OPT_ADDR_SMALL;

  always_ff @(posedge core_clk) begin
    if (srst)
      optWord_q <= `EPCRP_OPT_RESET;
    else if (hostOptWrite)
      optWord_q <= hostOptData;
  end

  assign hostOptRead       = optWord_q;
  assign resetPullupSelect = optWord_q[`EPCRP_OPT_PULLUP_BIT];

  // low-speed path: selected source halved
  epcrp_clkdiv u_lowDiv (
    .core_clk    (core_clk),
    .srst        (srst),
    .selExt      (lowClockSourceSwitch),
    .internalSrc (internalLowSrc),
    .userSrc     (userLowClockInput),
    .divOut      (lowDiv),
    .divTick     (lowTick)
  );

  // high-speed source: no stabilisation wait once started
  assign highSel = highClockSourceSwitch ? userHighClockInput : internalHighSrc;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lowSpeedClock  <= 1'b0;
      highSpeedClock <= 1'b0;
      coreClockOut   <= 1'b0;
      timeBaseTick   <= 1'b0;
    end else begin
      lowSpeedClock  <= lowDiv;
      highSpeedClock <= oscillatorStartBit & highSel;
      coreClockOut   <= coreClockSelHigh ? (oscillatorStartBit & highSel) : lowDiv;
      timeBaseTick   <= lowTick;
    end
  end

  // user reset only when enabled, run lit, and not single step or init
  assign userRstOk = userResetEnable & runIndicator &
                     ((emuMode == EPCRP_MODE_EVAL) | (emuMode == EPCRP_MODE_REALTM));

  always_ff @(posedge core_clk) begin
    if (srst)
      evalReset <= 1'b1;
    else
      evalReset <= ctrlReset | (userRstOk & ~userResetInput_n);
  end

  // comparator mode: port path cut, pins read as zero
  always_ff @(posedge core_clk) begin
    if (srst)
      sharedPortIn <= 2'b00;
    else
      sharedPortIn <= comparatorSelectSwitch ? 2'b00 : sharedPortPins;
  end

endmodule : epcrp_port

/* File: test/epcrp_port_properties.sv */
// Purpose: port-level timing checks of the probe, clock and reset block
// Assumes: one clock domain, srst synchronous and active high
// Notes:   latencies are the hand-over figures; bound from the bench top
`timescale 1ns/1ps
`include "epcrp_cfg.svh"
module epcrp_port_properties (
  input wire logic                       core_clk,
  input wire logic                       srst,
  input wire logic                       breakRequest,
  input wire logic                       instrS1Start,
  input wire logic                       instrS1Half,
  input wire logic                       instrS2Start,
  input wire logic                       syncPulseOut,
  input wire logic                       traceRecord,
  input wire logic [`EPCRP_PROBE_W-1:0]  traceProbeData,
  input wire epcrp_pkg::epcrp_mode_t     emuMode,
  input wire logic                       hostOptWrite,
  input wire logic [`EPCRP_OPT_W-1:0]    hostOptData,
  input wire logic [`EPCRP_OPT_W-1:0]    hostOptRead,
  input wire logic                       ctrlReset,
  input wire logic                       runIndicator,
  input wire logic                       evalReset,
  input wire logic                       comparatorSelectSwitch,
  input wire logic [1:0]                 sharedPortIn
);
  import epcrp_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // sync output must be back high just after the half-phase marker
  sequence sHalfEnd;
    instrS1Half ##[1:2] syncPulseOut;
  endsequence
  AST_BRK_AT_S2: assert property (breakRequest |-> $past(instrS2Start))
    else $error("break request not right after S2 start");
  AST_SYNC_LOW: assert property ($fell(syncPulseOut) |-> $past(instrS1Start, 2))
    else $error("sync output fell away from S1 start");
  AST_SYNC_END: assert property (instrS1Half |-> sHalfEnd)
    else $error("sync output low past first half of S1");
  AST_TRACE_MODE: assert property (traceRecord |-> $past(instrS1Start) && $past(emuMode) == EPCRP_MODE_REALTM)
    else $error("trace recorded outside real-time S1");
  AST_TRACE_HOLD: assert property (!$past(instrS1Start) |-> $stable(traceProbeData))
    else $error("probe data changed away from S1 start");
  AST_OPT_WRITE: assert property (hostOptWrite |=> hostOptRead == $past(hostOptData))
    else $error("option word not loaded");
  AST_CTRL_RST: assert property (ctrlReset |=> evalReset)
    else $error("controller reset not passed on");
  // srst in the antecedent: the edge that releases reset still loads evalReset high
  AST_USR_RST_GATE: assert property (!srst && !ctrlReset && (emuMode == EPCRP_MODE_STEP || !runIndicator) |=> !evalReset)
    else $error("user reset honoured while gated");
  AST_CMP_OFF: assert property (comparatorSelectSwitch |=> sharedPortIn == 2'h0)
    else $error("shared port input live in comparator mode");
endmodule : epcrp_port_properties

/* File: test/epcrp_target_model.sv */
// Purpose: target board and test equipment on the probe and user cables
// Assumes: pins change 1 ns after core_clk rises
// Notes:   user clocks run free, as a target oscillator would
`timescale 1ns/1ps
module epcrp_target_model (
  input  wire logic core_clk,
  output logic       externalBreakInput,
  output logic [3:0] probeTraceInputs,
  output logic [1:0] sharedPortPins,
  output logic       userResetInput_n,
  output logic       userLowClockInput,
  output logic       userHighClockInput
);
  int cnt = 0;
  initial begin
    {externalBreakInput, probeTraceInputs, sharedPortPins, userLowClockInput, userHighClockInput} = '0;
    userResetInput_n = 1'b1;
  end
  // low user clock runs at twice the wanted rate because the port halves it
  always @(posedge core_clk) begin
    #1;
    cnt++;
    userHighClockInput = cnt[1];
    userLowClockInput = cnt[3];
  end
  task automatic drive(input logic [3:0] p, input logic [1:0] s, input logic rn);
    {probeTraceInputs, sharedPortPins, userResetInput_n} = {p, s, rn};
  endtask : drive
  // held three cycles so the pin survives the two-stage synchroniser
  task automatic pulseBreak();
    externalBreakInput = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    externalBreakInput = 1'b0;
  endtask : pulseBreak
endmodule : epcrp_target_model

/* File: test/emulator_probe_clock_reset_port_tb_top.sv */
// Purpose: self-checking bench for the probe, clock and reset block
// Assumes: 125 MHz core_clk, srst held for 20 cycles
// Notes:   all inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "epcrp_cfg.svh"
module emulator_probe_clock_reset_port_tb_top;
  import epcrp_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, syncPulseOut, breakRequest, traceRecord, resetPullupSelect, evalReset;
  logic lowSpeedClock, highSpeedClock, coreClockOut, timeBaseTick, extBreakEnable, instrS1Start, instrS1Half;
  logic instrS2Start, instrFirstWord, runIndicator, hostSyncWrite, hostSyncData, hostOptWrite, largeMap;
  logic lowClockSourceSwitch, highClockSourceSwitch, internalLowSrc, internalHighSrc, oscillatorStartBit;
  logic coreClockSelHigh, ctrlReset, userResetEnable, comparatorSelectSwitch, externalBreakInput;
  logic userResetInput_n, userLowClockInput, userHighClockInput, sawLow, sawBrk, sawTrc;
  logic [`EPCRP_PROBE_W-1:0] probeTraceInputs, traceProbeData, hostOptData, hostOptRead;
  logic [`EPCRP_ADDR_W-1:0] instrAddr, hostSyncAddr;
  logic [1:0] sharedPortPins, sharedPortIn;
  logic [7:0] lc, hc, cc, tk;
  epcrp_mode_t emuMode;
  int badCount = 0, compares = 0, cyc = 0;
  epcrp_port dut (.*);
  epcrp_target_model tgt (.core_clk, .externalBreakInput, .probeTraceInputs, .sharedPortPins,
    .userResetInput_n, .userLowClockInput, .userHighClockInput);
  always #4 core_clk = ~core_clk;
  // a hang ends the run as a mismatch
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      endSim();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one instruction: S1 start, S1 half, S2 start, ten cycles in all
  task automatic instr(input logic [12:0] a, input logic first);
    {sawLow, sawBrk, sawTrc} = 3'h0;
    {instrAddr, instrFirstWord} = {a, first};
    for (int c = 0; c < 10; c++) begin
      {instrS1Start, instrS1Half, instrS2Start} = {c == 0, c == 3, c == 6};
      tick(1);
      {sawLow, sawBrk, sawTrc} = {sawLow | ~syncPulseOut, sawBrk | breakRequest, sawTrc | traceRecord};
    end
  endtask : instr
  task automatic wsync(input logic [12:0] a, input logic d);
    {hostSyncAddr, hostSyncData, hostSyncWrite} = {a, d, 1'b1};
    tick(1);
    hostSyncWrite = 1'b0;
  endtask : wsync
  task automatic rchk(input epcrp_mode_t m, input logic run, en, ctl, exp);
    emuMode = m;
    {runIndicator, userResetEnable, ctrlReset} = {run, en, ctl};
    tick(2);
    chk("eval reset", exp, evalReset);
  endtask : rchk
  // counts clock changes over 128 cycles; phase does not matter for these periods
  task automatic win();
    logic pl, ph, pc;
    {lc, hc, cc, tk} = '0;
    for (int c = 0; c < 128; c++) begin
      {pl, ph, pc} = {lowSpeedClock, highSpeedClock, coreClockOut};
      tick(1);
      {lc, hc, cc, tk} = {lc + (lowSpeedClock != pl), hc + (highSpeedClock != ph), cc + (coreClockOut != pc),
                          tk + timeBaseTick};
    end
  endtask : win
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : endSim
  initial begin
    {extBreakEnable, instrS1Start, instrS1Half, instrS2Start, instrFirstWord, runIndicator, hostSyncWrite,
     hostSyncData, hostOptWrite, largeMap, lowClockSourceSwitch, highClockSourceSwitch, internalLowSrc,
     internalHighSrc, oscillatorStartBit, coreClockSelHigh, ctrlReset, userResetEnable,
     comparatorSelectSwitch, instrAddr, hostSyncAddr, hostOptData} = '0;
    emuMode = EPCRP_MODE_EVAL;
    tick(20);
    srst = 1'b0;
    tick(3);
    chk("option reset", `EPCRP_OPT_RESET, hostOptRead);
    wsync(13'h0005, 1'b1);
    wsync(13'h0006, 1'b0);
    instr(13'h0005, 1'b1);
    chk("sync marked", 1'b1, sawLow);
    instr(13'h0006, 1'b1);
    chk("sync unmarked", 1'b0, sawLow);
    instr(13'h0005, 1'b0);
    chk("sync second word", 1'b0, sawLow);
    $display("sync test done");
    tgt.drive(4'ha, 2'h3, 1'b1);
    emuMode = EPCRP_MODE_REALTM;
    tick(4);
    instr(13'h0006, 1'b1);
    chk("probe data", 4'ha, traceProbeData);
    chk("trace realtime", 1'b1, sawTrc);
    emuMode = EPCRP_MODE_STEP;
    instr(13'h0006, 1'b1);
    chk("trace step", 1'b0, sawTrc);
    extBreakEnable = 1'b1;
    tgt.pulseBreak();
    instr(13'h0006, 1'b1);
    chk("break enabled", 1'b1, sawBrk);
    extBreakEnable = 1'b0;
    tgt.pulseBreak();
    instr(13'h0006, 1'b1);
    chk("break disabled", 1'b0, sawBrk);
    $display("probe test done");
    for (int i = 0; i < 2; i++) begin
      {hostOptData, hostOptWrite} = {i ? 4'ha : 4'h5, 1'b1};
      tick(1);
      hostOptWrite = 1'b0;
      tick(1);
      chk("option word", i ? 4'ha : 4'h5, hostOptRead);
      chk("pull-up", i ? 1'b0 : 1'b1, resetPullupSelect);
    end
    tick(2);
    chk("port in", 2'h3, sharedPortIn);
    comparatorSelectSwitch = 1'b1;
    tick(2);
    chk("port cut", 2'h0, sharedPortIn);
    $display("option and port test done");
    tgt.drive(4'ha, 2'h3, 1'b0);
    rchk(EPCRP_MODE_REALTM, 1'b1, 1'b1, 1'b0, 1'b1);
    rchk(EPCRP_MODE_EVAL, 1'b1, 1'b1, 1'b0, 1'b1);
    rchk(EPCRP_MODE_STEP, 1'b1, 1'b1, 1'b0, 1'b0);
    rchk(EPCRP_MODE_REALTM, 1'b0, 1'b1, 1'b0, 1'b0);
    rchk(EPCRP_MODE_REALTM, 1'b1, 1'b0, 1'b0, 1'b0);
    rchk(EPCRP_MODE_STEP, 1'b0, 1'b0, 1'b1, 1'b1);
    ctrlReset = 1'b0;
    tgt.drive(4'ha, 2'h3, 1'b1);
    $display("reset test done");
    {lowClockSourceSwitch, highClockSourceSwitch, oscillatorStartBit, coreClockSelHigh} = 4'hf;
    tick(8);
    win();
    chk("low clock changes", 8'h08, lc);
    chk("time-base ticks", 8'h04, tk);
    chk("high clock changes", 8'h40, hc);
    chk("core on high", 8'h40, cc);
    coreClockSelHigh = 1'b0;
    tick(8);
    win();
    chk("core on low", 8'h08, cc);
    chk("ticks on low core", 8'h04, tk);
    $display("clock test done");
    endSim();
  end
endmodule : emulator_probe_clock_reset_port_tb_top

bind epcrp_port epcrp_port_properties u_props (.core_clk, .srst, .breakRequest, .instrS1Start, .instrS1Half,
  .instrS2Start, .syncPulseOut, .traceRecord, .traceProbeData, .emuMode, .hostOptWrite, .hostOptData,
  .hostOptRead, .ctrlReset, .runIndicator, .evalReset, .comparatorSelectSwitch, .sharedPortIn);
